// [verilog/e1tpc_pkg.sv]
// Purpose: Constants shared by the E1 trunk pin control and status block
// Assumes: One core clock at 100 MHz; all E1 clocks arrive as sampled pins
// Notes: Timeslot placement of control and status words is fixed here
package e1tpc_pkg;
  localparam int CORE_CLK_MHZ = 100;
  localparam int SYNC_STAGES = 2;
  localparam int BITS_PER_FRAME = 256;
  localparam int SLOTS_PER_FRAME = 32;
  localparam int LINE_DIV_HALF = 128;
  // Control input stream zero
  localparam logic [4:0] TS_MCW_ONE = 5'h00;
  localparam logic [4:0] TS_MCW_TWO = 5'h10;
  localparam int MASTER_CONTROL_WORD_TWO_AUX_BIT = 1;
  localparam int MASTER_CONTROL_WORD_TWO_CLK8K_EN_BIT = 0;
  localparam int PCW_VOICE_BIT = 0;
  // Control output stream
  localparam logic [4:0] TS_SIG_LAST = 5'h0f;
  localparam logic [4:0] TS_MSW_ONE = 5'h10;
  localparam logic [4:0] TS_MSW_TWO = 5'h11;
  localparam logic [4:0] TS_PHASE = 5'h12;
  localparam logic [4:0] TS_CRC_CNT = 5'h13;
  localparam int MASTER_STATUS_WORD_ONE_SYNC_BIT = 0;
  localparam int MASTER_STATUS_WORD_ONE_AUX_BIT = 1;
  // Line framing
  localparam logic [6:0] FAS_PATTERN = 7'h1b;
  localparam logic [4:0] TS_SIGNALLING = 5'h10;
  localparam logic [7:0] ADI_MASK = 8'h55;
  localparam logic [7:0] NFAS_WORD = 8'h40;
  localparam int FAS_MISS_LIMIT = 3;
  localparam int LOS_ZERO_BITS = 32;
  // AHB register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam int IRQ_SYNC_GAIN = 0;
  localparam int IRQ_SYNC_LOSS = 1;
  localparam int IRQ_AUX_CHANGE = 2;
  localparam int IRQ_BITS = 3;
  typedef enum logic [1:0] {SYNC_LOST, SYNC_LOCKED} e1tpc_sync_e;
endpackage : e1tpc_pkg

// [verilog/e1tpc_top.sv]
// Operation
// - 8 kHz output is line clock divided by 256, aligned to received frame
// - 8 kHz output held low when signal or basic frame sync is lost
// - 8 kHz output tristated while its enable bit in control word two is 0
// - Aux control output follows bit 1 of control word two on stream zero
// - Aux control output changes only once per frame
// - Aux status sampled once per frame, reported in status word one bit 1
// - Digit inversion on voice channels when select high, none when low
// - Received channel data leaves on a 2048 kbit/s system data stream
// - Control out stream carries 16 signalling, two status, phase, error count
// - Accepts unipolar NRZ or RZ data plus two split-phase inputs
// - Drives two complementary split-phase unipolar transmit outputs
// - System bus frames are 125 us of 32 eight-bit channels
// - System bus sampled on clock falling edge, launched on rising edge
// - Line data latched on falling edge of the recovered line clock
// Purpose: E1 trunk pin-level control, status and serial stream handling
// Assumes: Every E1 pin is asynchronous to i_core_clk and much slower
// Notes: Registers on AHB-Lite, zero wait state; one level interrupt
`timescale 1ns/1ns
`default_nettype none
module e1tpc_top
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_hsel,
  input wire logic [7:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  output logic o_irq,
  input wire logic i_system_bit_clock,
  input wire logic i_system_frame_pulse,
  input wire logic i_sys_data_in_stream,
  input wire logic i_ctrl_in_stream_zero,
  input wire logic i_ctrl_in_stream_one,
  output logic o_sys_data_out_stream,
  output logic o_ctrl_out_stream,
  input wire logic i_recovered_line_clock,
  input wire logic i_line_rx_phase_a,
  input wire logic i_line_rx_phase_b,
  input wire logic i_line_rx_data,
  output logic o_line_tx_phase_a,
  output logic o_line_tx_phase_b,
  output logic o_recovered_8k_clock_out,
  output logic o_recovered_8k_clock_oe,
  output logic o_aux_control_out,
  input wire logic i_aux_status_in,
  input wire logic i_digit_inversion_select
);
  localparam int NPIN = 11;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  assign pin_raw = {i_digit_inversion_select, i_aux_status_in, i_line_rx_data, i_line_rx_phase_b,
                    i_line_rx_phase_a, i_recovered_line_clock, i_ctrl_in_stream_one,
                    i_ctrl_in_stream_zero, i_sys_data_in_stream, i_system_frame_pulse, i_system_bit_clock};
  // Two-stage synchronisers; stage one feeds stage two only
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else if (i_clk_en)
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end
  logic sclk_q;
  logic lclk_q;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      sclk_q <= 1'b0;
      lclk_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      sclk_q <= pin_sync[0];
      lclk_q <= pin_sync[5];
    end
  end
  logic sclk_fall;
  logic sclk_rise;
  logic lclk_fall;
  assign sclk_fall = i_clk_en && sclk_q && !pin_sync[0];
  assign sclk_rise = i_clk_en && !sclk_q && pin_sync[0];
  assign lclk_fall = i_clk_en && lclk_q && !pin_sync[5];
  logic frame_pulse_s;
  logic din_s;
  logic cin0_s;
  logic cin1_s;
  logic rx_bit_s;
  logic aux_st_s;
  logic adi_sel_s;
  assign frame_pulse_s = pin_sync[1];
  assign din_s = pin_sync[2];
  assign cin0_s = pin_sync[3];
  assign cin1_s = pin_sync[4];
  // NRZ or RZ data both read at mid-bit; split-phase marks also count
  assign rx_bit_s = pin_sync[8] | pin_sync[6] | pin_sync[7];
  assign aux_st_s = pin_sync[9];
  assign adi_sel_s = pin_sync[10];

  // System bus side
  logic [7:0] sys_bit;
  logic [7:0] din_sh;
  logic [7:0] cin0_sh;
  logic [7:0] cin1_sh;
  logic [7:0] tx_frame [e1tpc_pkg::SLOTS_PER_FRAME];
  logic [31:0] voice_map;
  logic [7:0] mcw_two_pend;
  logic [7:0] mcw_two;
  logic [7:0] diag_word;
  logic sys_frame_start;
  logic [4:0] sys_ts;
  logic [2:0] sys_bi;
  logic [7:0] in_bit;
  logic [4:0] in_ts;
  logic [2:0] in_bi;
  logic [7:0] out_bit;
  logic [4:0] out_ts;
  logic [2:0] out_bi;
  logic [7:0] cin0_byte;
  assign sys_ts = sys_bit[7:3];
  assign sys_bi = sys_bit[2:0];
  // Bit sampled at this falling edge; the pulse marks bit 0
  assign in_bit = frame_pulse_s ? 8'h00 : sys_bit + 8'h01;
  assign in_ts = in_bit[7:3];
  assign in_bi = in_bit[2:0];
  // Rising edge launches the bit after the one last sampled
  assign out_bit = sys_bit + 8'h01;
  assign out_ts = out_bit[7:3];
  assign out_bi = out_bit[2:0];
  assign cin0_byte = {cin0_sh[6:0], cin0_s};
  assign sys_frame_start = sclk_fall && frame_pulse_s;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      sys_bit <= '0;
      din_sh <= '0;
      cin0_sh <= '0;
      cin1_sh <= '0;
      voice_map <= '0;
      mcw_two_pend <= '0;
      diag_word <= '0;
    end
    else if (sclk_fall)
    begin
      din_sh <= {din_sh[6:0], din_s};
      cin0_sh <= {cin0_sh[6:0], cin0_s};
      cin1_sh <= {cin1_sh[6:0], cin1_s};
      sys_bit <= in_bit;
      if (in_bi == 3'h7)
      begin
        if (in_ts == e1tpc_pkg::TS_MCW_TWO)
          mcw_two_pend <= cin0_byte;
        else if (in_ts != e1tpc_pkg::TS_MCW_ONE)
          voice_map[in_ts] <= cin0_byte[e1tpc_pkg::PCW_VOICE_BIT];
        if (in_ts == e1tpc_pkg::TS_MCW_ONE)
          diag_word <= {cin1_sh[6:0], cin1_s};
      end
    end
  end
  always_ff @(posedge i_core_clk)
  begin
    if (sclk_fall && in_bi == 3'h7)
      tx_frame[in_ts] <= {din_sh[6:0], din_s} ^
                         ((adi_sel_s && voice_map[in_ts]) ? e1tpc_pkg::ADI_MASK : 8'h00);
  end
  logic aux_status_held;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      mcw_two <= '0;
      aux_status_held <= 1'b0;
    end
    else if (sys_frame_start)
    begin
      mcw_two <= mcw_two_pend;
      aux_status_held <= aux_st_s;
    end
  end
  assign o_aux_control_out = mcw_two[e1tpc_pkg::MASTER_CONTROL_WORD_TWO_AUX_BIT];

  // Line receive side
  e1tpc_pkg::e1tpc_sync_e sync_state;
  logic [7:0] line_bit;
  logic [7:0] rx_sh;
  logic [7:0] rx_frame [e1tpc_pkg::SLOTS_PER_FRAME];
  logic [1:0] fas_miss;
  logic [5:0] zero_run;
  logic fas_frame;
  logic [7:0] crc_err_count;
  logic [7:0] sig_word;
  logic [7:0] rx_byte;
  logic fas_seen;
  assign rx_byte = {rx_sh[6:0], rx_bit_s};
  assign fas_seen = rx_byte[6:0] == e1tpc_pkg::FAS_PATTERN;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      sync_state <= e1tpc_pkg::SYNC_LOST;
      line_bit <= '0;
      rx_sh <= '0;
      fas_miss <= '0;
      zero_run <= '0;
      fas_frame <= 1'b0;
      crc_err_count <= '0;
      sig_word <= '0;
    end
    else if (lclk_fall)
    begin
      rx_sh <= rx_byte;
      line_bit <= line_bit + 8'h01;
      zero_run <= rx_bit_s ? 6'h00 :
                  (zero_run == 6'(e1tpc_pkg::LOS_ZERO_BITS) ? zero_run : zero_run + 6'h01);
      if (line_bit == 8'hff)
        fas_frame <= !fas_frame;
      if (line_bit[2:0] == 3'h7 && line_bit[7:3] == e1tpc_pkg::TS_SIGNALLING)
        sig_word <= rx_byte;
      case (sync_state)
        e1tpc_pkg::SYNC_LOST:
        begin
          if (fas_seen)
          begin
            sync_state <= e1tpc_pkg::SYNC_LOCKED;
            line_bit <= 8'h08;
            fas_frame <= 1'b1;
            fas_miss <= '0;
          end
        end
        e1tpc_pkg::SYNC_LOCKED:
        begin
          if (zero_run == 6'(e1tpc_pkg::LOS_ZERO_BITS))
            sync_state <= e1tpc_pkg::SYNC_LOST;
          else if (line_bit == 8'h07 && fas_frame)
          begin
            if (fas_seen)
              fas_miss <= '0;
            else
            begin
              crc_err_count <= crc_err_count + 8'h01;
              fas_miss <= fas_miss + 2'h1;
              if (fas_miss == 2'(e1tpc_pkg::FAS_MISS_LIMIT - 1))
                sync_state <= e1tpc_pkg::SYNC_LOST;
            end
          end
        end
        default: sync_state <= e1tpc_pkg::SYNC_LOST;
      endcase
    end
  end
  always_ff @(posedge i_core_clk)
  begin
    if (lclk_fall && line_bit[2:0] == 3'h7)
      rx_frame[line_bit[7:3]] <= rx_byte;
  end
  logic synced;
  assign synced = sync_state == e1tpc_pkg::SYNC_LOCKED;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_recovered_8k_clock_out <= 1'b0;
      o_recovered_8k_clock_oe <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_recovered_8k_clock_out <= synced && line_bit < 8'(e1tpc_pkg::LINE_DIV_HALF);
      o_recovered_8k_clock_oe <= mcw_two[e1tpc_pkg::MASTER_CONTROL_WORD_TWO_CLK8K_EN_BIT];
    end
  end

  // Serial outputs launched on the system clock rising edge
  logic [7:0] cout_word;
  logic [7:0] dout_word;
  always_comb
  begin
    dout_word = rx_frame[out_ts] ^ ((adi_sel_s && voice_map[out_ts]) ? e1tpc_pkg::ADI_MASK : 8'h00);
    if (out_ts <= e1tpc_pkg::TS_SIG_LAST)
      cout_word = sig_word;
    else if (out_ts == e1tpc_pkg::TS_MSW_ONE)
      cout_word = {6'h00, aux_status_held, synced};
    else if (out_ts == e1tpc_pkg::TS_MSW_TWO)
      cout_word = diag_word;
    else if (out_ts == e1tpc_pkg::TS_PHASE)
      cout_word = line_bit;
    else if (out_ts == e1tpc_pkg::TS_CRC_CNT)
      cout_word = crc_err_count;
    else
      cout_word = 8'h00;
  end
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      o_sys_data_out_stream <= 1'b0;
      o_ctrl_out_stream <= 1'b0;
    end
    else if (sclk_rise)
    begin
      o_sys_data_out_stream <= dout_word[3'h7 - out_bi];
      o_ctrl_out_stream <= cout_word[3'h7 - out_bi];
    end
  end

  // Line transmit, alternate mark inversion on the two phases
  logic [31:0] ctrl_reg;
  logic tx_pol;
  logic tx_fas;
  logic [7:0] tx_word;
  logic tx_mark;
  assign tx_word = (sys_ts == 5'h00) ? (tx_fas ? {1'b0, e1tpc_pkg::FAS_PATTERN} : e1tpc_pkg::NFAS_WORD) :
                   tx_frame[sys_ts];
  assign tx_mark = tx_word[3'h7 - sys_bi];
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      tx_pol <= 1'b0;
      tx_fas <= 1'b0;
      o_line_tx_phase_a <= 1'b0;
      o_line_tx_phase_b <= 1'b0;
    end
    else if (sclk_fall)
    begin
      if (sys_bit == 8'hff)
        tx_fas <= !tx_fas;
      if (tx_mark && ctrl_reg[0])
        tx_pol <= !tx_pol;
      o_line_tx_phase_a <= ctrl_reg[0] && tx_mark && !tx_pol;
      o_line_tx_phase_b <= ctrl_reg[0] && tx_mark && tx_pol;
    end
  end

  // AHB-Lite slave, zero wait states
  logic [e1tpc_pkg::IRQ_BITS-1:0] irq_status;
  logic [e1tpc_pkg::IRQ_BITS-1:0] irq_mask;
  logic [e1tpc_pkg::IRQ_BITS-1:0] irq_event;
  logic synced_q;
  logic aux_q;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic acc;
  logic rd_clr;
  assign acc = i_clk_en && i_hsel && i_hready && i_htrans[1];
  assign rd_clr = acc && !i_hwrite && i_haddr == e1tpc_pkg::ADDR_IRQ_STATUS;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign irq_event[e1tpc_pkg::IRQ_SYNC_GAIN] = synced && !synced_q;
  assign irq_event[e1tpc_pkg::IRQ_SYNC_LOSS] = !synced && synced_q;
  assign irq_event[e1tpc_pkg::IRQ_AUX_CHANGE] = aux_status_held != aux_q;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      synced_q <= 1'b0;
      aux_q <= 1'b0;
      irq_status <= '0;
      o_irq <= 1'b0;
    end
    else if (i_clk_en)
    begin
      synced_q <= synced;
      aux_q <= aux_status_held;
      // A new event beats the read that clears
      irq_status <= (rd_clr ? '0 : irq_status) | irq_event;
      o_irq <= |(irq_status & irq_mask);
    end
  end
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      ctrl_reg <= e1tpc_pkg::CTRL_RESET;
      irq_mask <= '0;
      wr_pend <= 1'b0;
      wr_addr <= '0;
      o_hrdata <= '0;
    end
    else if (i_clk_en)
    begin
      wr_pend <= acc && i_hwrite;
      wr_addr <= i_haddr;
      if (wr_pend && wr_addr == e1tpc_pkg::ADDR_CTRL)
        ctrl_reg <= {31'h0, i_hwdata[0]};
      else if (wr_pend && wr_addr == e1tpc_pkg::ADDR_IRQ_MASK)
        irq_mask <= i_hwdata[e1tpc_pkg::IRQ_BITS-1:0];
      if (acc && !i_hwrite)
      begin
        if (i_haddr == e1tpc_pkg::ADDR_CTRL)
          o_hrdata <= ctrl_reg;
        else if (i_haddr == e1tpc_pkg::ADDR_STATUS)
          o_hrdata <= {16'h0, crc_err_count, 4'h0, mcw_two[e1tpc_pkg::MASTER_CONTROL_WORD_TWO_CLK8K_EN_BIT], o_aux_control_out,
                       aux_status_held, synced};
        else if (i_haddr == e1tpc_pkg::ADDR_IRQ_STATUS)
          o_hrdata <= {29'h0, irq_status};
        else if (i_haddr == e1tpc_pkg::ADDR_IRQ_MASK)
          o_hrdata <= {29'h0, irq_mask};
        else
          o_hrdata <= 32'h0;
      end
    end
  end

  // Checks
  aux_frame_only_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !sys_frame_start |=> $stable(o_aux_control_out)) else $error("aux control moved mid-frame");
  aux_follows_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    sys_frame_start |=> o_aux_control_out == $past(mcw_two_pend[e1tpc_pkg::MASTER_CONTROL_WORD_TWO_AUX_BIT]))
    else $error("aux control wrong");
  status_sample_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    sys_frame_start |=> aux_status_held == $past(aux_st_s)) else $error("aux status not sampled");
  clk8k_low_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && !synced) |=> !o_recovered_8k_clock_out) else $error("8k high without sync");
  clk8k_phase_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && synced && line_bit == 8'h80) |=> !o_recovered_8k_clock_out) else $error("8k phase wrong");
  clk8k_oe_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && !mcw_two[e1tpc_pkg::MASTER_CONTROL_WORD_TWO_CLK8K_EN_BIT]) |=> !o_recovered_8k_clock_oe)
    else $error("8k not released");
  tx_split_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !(o_line_tx_phase_a && o_line_tx_phase_b)) else $error("both tx phases high");
  frame_wrap_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    sys_frame_start |=> sys_bit == 8'h00) else $error("frame pulse not aligning");
  line_latch_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_clk_en && !lclk_fall) |=> $stable(rx_sh)) else $error("line data moved off edge");
  sync_cov_c: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) irq_event[e1tpc_pkg::IRQ_SYNC_GAIN]);
  loss_cov_c: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) irq_event[e1tpc_pkg::IRQ_SYNC_LOSS]);
  aux_cov_c: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) $rose(o_aux_control_out));
endmodule : e1tpc_top
`default_nettype wire

// [test/e1tpc_sys_master.sv]
// Purpose: System bus master model: bit clock, frame pulse and input streams
// Assumes: Bit clock is the core clock divided by 16 to keep runs short
// Notes: Control output bytes are captured per timeslot for the bench
`timescale 1ns/1ns
`default_nettype none
module e1tpc_sys_master
(
  input wire logic i_core_clk,
  input wire logic [7:0] i_master_control_word_two,
  input wire logic [7:0] i_diag,
  input wire logic [7:0] i_fill,
  input wire logic i_voice,
  input wire logic i_ctrl_out,
  output logic o_bit_clk = 1'b1,
  output logic o_frame_pulse = 1'b0,
  output logic o_data = 1'b0,
  output logic o_ctrl0 = 1'b0,
  output logic o_ctrl1 = 1'b0,
  output logic [7:0] o_bit_cnt = 8'hff
);
  logic [3:0] div = 4'h0;
  logic [7:0] nb;
  logic [7:0] w0;
  logic [7:0] cap_byte [32];
  always @(posedge i_core_clk)
  begin
    div <= div + 4'h1;
    if (div == 4'h7)
    begin
      o_bit_clk <= 1'b0;
      cap_byte[o_bit_cnt[7:3]] <= {cap_byte[o_bit_cnt[7:3]][6:0], i_ctrl_out};
    end
    if (div == 4'hf)
    begin
      nb = o_bit_cnt + 8'h01;
      w0 = (nb[7:3] == e1tpc_pkg::TS_MCW_TWO) ? i_master_control_word_two : {7'h00, i_voice & (nb[7:3] != 5'h00)};
      o_bit_clk <= 1'b1;
      o_bit_cnt <= nb;
      o_frame_pulse <= (nb == 8'h00);
      o_ctrl0 <= w0[~nb[2:0]];
      o_ctrl1 <= (nb[7:3] == 5'h00) ? i_diag[~nb[2:0]] : 1'b0;
      o_data <= i_fill[~nb[2:0]] ^ nb[3];
    end
  end
endmodule : e1tpc_sys_master
`default_nettype wire

// [test/tb_top.sv]
// Purpose: Self-checking bench for the E1 pin control and status block
// Assumes: Transmit phases loop back to the receive phases
// Notes: Line clock is the inverted bit clock, centring rx samples
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_hsel = 1'b0;
  logic i_hwrite = 1'b0;
  logic [7:0] i_haddr = 8'h00;
  logic [1:0] i_htrans = 2'h0;
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] i_hwdata = 32'h0;
  logic [7:0] master_control_word_two = 8'h00;
  logic [7:0] diag = 8'h00;
  logic [7:0] fill = 8'h00;
  logic voice = 1'b0;
  logic digit_inversion_select = 1'b0;
  logic aux_in = 1'b0;
  logic hrdy, hresp, irq, dout, cout, tx_a, tx_b, k8, k8_oe, aux_out, bclk, fp, sdi, c0, c1;
  logic [31:0] hrdata;
  logic [7:0] bit_cnt;
  logic [31:0] seed = 32'd79388;
  logic prev_aux = 1'b0;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #5 i_core_clk = ~i_core_clk;

  e1tpc_sys_master partner_u (.i_core_clk(i_core_clk), .i_master_control_word_two(master_control_word_two), .i_diag(diag), .i_fill(fill),
    .i_voice(voice), .i_ctrl_out(cout), .o_bit_clk(bclk), .o_frame_pulse(fp), .o_data(sdi), .o_ctrl0(c0),
    .o_ctrl1(c1), .o_bit_cnt(bit_cnt));

  e1tpc_top dut_u (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_clk_en(1'b1), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata), .o_irq(irq),
    .i_system_bit_clock(bclk), .i_system_frame_pulse(fp), .i_sys_data_in_stream(sdi),
    .i_ctrl_in_stream_zero(c0), .i_ctrl_in_stream_one(c1), .o_sys_data_out_stream(dout),
    .o_ctrl_out_stream(cout), .i_recovered_line_clock(~bclk), .i_line_rx_phase_a(tx_a),
    .i_line_rx_phase_b(tx_b), .i_line_rx_data(1'b0), .o_line_tx_phase_a(tx_a), .o_line_tx_phase_b(tx_b),
    .o_recovered_8k_clock_out(k8), .o_recovered_8k_clock_oe(k8_oe), .o_aux_control_out(aux_out),
    .i_aux_status_in(aux_in), .i_digit_inversion_select(digit_inversion_select));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task stop_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // Waits lean on the global timeout, never on a guessed latency
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_core_clk);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= a;
    i_hwrite <= wr;
    do @(posedge i_core_clk); while (hrdy !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_core_clk); while (hrdy !== 1'b1);
    rd = hrdata;
    i_hsel <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r & m, e, s);
  endtask : rd_chk

  // Fresh random payload, voice marking and inversion select every frame
  task automatic frames(input int n);
    repeat (n)
    begin
      seed = lfsr(seed);
      fill <= seed[7:0];
      voice <= seed[8];
      digit_inversion_select <= seed[9];
      repeat (4096) @(posedge i_core_clk);
    end
  endtask : frames

  always @(posedge i_core_clk)
  begin
    cycles++;
    prev_aux <= aux_out;
    if (i_reset_n && (tx_a & tx_b))
      check(1, 0, "tx phases both high");
    if (i_reset_n && aux_out !== prev_aux)
      check(bit_cnt < 8'h02, 1, "aux output moved mid-frame");
    if (cycles == 95000)
    begin
      num_errors++;
      stop_test();
    end
  end

  initial
  begin
    int hi;
    int lo;
    repeat (20) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    @(posedge i_core_clk);
    check({k8, k8_oe, aux_out, irq, hrdy, hresp}, 6'h02, "outputs after reset");
    rd_chk(e1tpc_pkg::ADDR_CTRL, 32'hffffffff, e1tpc_pkg::CTRL_RESET, "ctrl reset");
    rd_chk(e1tpc_pkg::ADDR_IRQ_MASK, 32'hffffffff, 32'h0, "mask reset");
    wr(8'h20, 32'hffffffff);
    rd_chk(8'h20, 32'hffffffff, 32'h0, "unmapped read");
    wr(e1tpc_pkg::ADDR_IRQ_MASK, 32'h7);
    seed = lfsr(seed);
    diag <= seed[23:16];
    master_control_word_two <= 8'h03;
    frames(3);
    check(irq, 1, "irq on sync gain");
    rd_chk(e1tpc_pkg::ADDR_IRQ_STATUS, 32'h1, 32'h1, "sync gain event");
    repeat (3) @(posedge i_core_clk);
    check(irq, 0, "irq after read clear");
    check({k8_oe, aux_out}, 2'b11, "8k enable and aux out on");
    check(partner_u.cap_byte[16][1:0], 2'b01, "status word one synced");
    check(partner_u.cap_byte[17], diag, "diag echo slot");
    for (int t = 20; t < 32; t++)
      check(partner_u.cap_byte[t], 8'h00, "spare control out slot");
    hi = 0;
    lo = 0;
    while (k8 !== 1'b1) @(posedge i_core_clk);
    while (k8 === 1'b1)
    begin
      hi++;
      @(posedge i_core_clk);
    end
    while (k8 === 1'b0)
    begin
      lo++;
      @(posedge i_core_clk);
    end
    check(hi >= 2032 && hi <= 2064, 1, "8k high half");
    check(lo >= 2032 && lo <= 2064, 1, "8k low half");
    aux_in <= 1'b1;
    master_control_word_two <= 8'h01;
    frames(2);
    check(aux_out, 0, "aux out cleared");
    rd_chk(e1tpc_pkg::ADDR_STATUS, 32'hf, 32'hb, "status aux and sync");
    check(partner_u.cap_byte[16][1:0], 2'b11, "status word one aux");
    rd_chk(e1tpc_pkg::ADDR_IRQ_STATUS, 32'h4, 32'h4, "aux change event");
    wr(e1tpc_pkg::ADDR_IRQ_MASK, 32'h0);
    wr(e1tpc_pkg::ADDR_CTRL, 32'h0);
    frames(2);
    check({tx_a, tx_b, irq}, 3'b000, "tx off, masked irq");
    rd_chk(e1tpc_pkg::ADDR_STATUS, 32'h1, 32'h0, "sync lost");
    hi = 0;
    repeat (4200)
    begin
      hi += k8;
      @(posedge i_core_clk);
    end
    check(hi, 0, "8k held low without sync");
    wr(e1tpc_pkg::ADDR_IRQ_MASK, 32'h2);
    repeat (3) @(posedge i_core_clk);
    check(irq, 1, "unmasked loss irq");
    rd_chk(e1tpc_pkg::ADDR_IRQ_STATUS, 32'h2, 32'h2, "sync loss event");
    master_control_word_two <= 8'h00;
    frames(2);
    check(k8_oe, 0, "8k pin released");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
